// file: rpd_defines.svh
`ifndef RPD_DEFINES_SVH
`define RPD_DEFINES_SVH

// Register offsets (byte addresses)
`define RPD_CTRL_OFS       8'h00
`define RPD_STATUS_OFS     8'h04
`define RPD_CAUSE_OFS      8'h08
`define RPD_IRQEN_OFS      8'h0C

// Control field positions
`define RPD_IRQ_SEL_LSB    0
`define RPD_RST_SEL_LSB    2
`define RPD_RST_EN_BIT     4
`define RPD_REMAP_OFF_BIT  5
`define RPD_CLK_SRC_LSB    6
`define RPD_CTRL_W         8

// Control reset value: brownout reset on, lowest thresholds, boot map on
`define RPD_CTRL_RST       8'h10
`define RPD_CLK_RC         2'h0

// Status field positions
`define RPD_ST_IRQ_BIT     0
`define RPD_ST_LEVEL_BIT   1
`define RPD_ST_LOCK_LSB    2
`define RPD_ST_SCAN_BIT    4
`define RPD_ST_PINOFF_BIT  5

// Reset cause bits
`define RPD_CAUSE_PIN      0
`define RPD_CAUSE_WDT      1
`define RPD_CAUSE_POR      2
`define RPD_CAUSE_BROWN    3

// Flash lock words; values are arbitrary
`define RPD_LOCK1_WORD     32'h1234_5671
`define RPD_LOCK2_WORD     32'h1234_5672
`define RPD_LOCK3_WORD     32'h1234_5673
`define RPD_NOPIN_WORD     32'h1234_5670

// Timing
`define RPD_PIN_MIN_NS     50
`define RPD_CLK_NS         40
`define RPD_HOLD_CYC       4'h8
`define RPD_BOOT_VECTOR    32'h0000_0000

`endif

// file: rpd_pkg.sv
package rpd_pkg;

    typedef enum logic [2:0] {
        RPD_HOLD  = 3'b001,
        RPD_FLASH = 3'b010,
        RPD_RUN   = 3'b100
    } rpd_state_t;

    typedef enum logic [1:0] {
        RPD_OPEN  = 2'h0,
        RPD_LVL1  = 2'h1,
        RPD_LVL2  = 2'h2,
        RPD_LVL3  = 2'h3
    } rpd_lock_t;

    typedef enum logic [2:0] {
        RPD_OP_READ      = 3'h0,
        RPD_OP_WRITE     = 3'h1,
        RPD_OP_ERASE_SEC = 3'h2,
        RPD_OP_ERASE_ALL = 3'h3,
        RPD_OP_GO        = 3'h4
    } rpd_op_t;

    typedef struct packed {
        rpd_op_t    op;
        logic [3:0] sector;
    } rpd_isp_cmd_t;

    typedef struct packed {
        logic       pin;
        logic       wdt;
        logic       por;
        logic       brownout;
    } rpd_src_t;

endpackage

// file: rpd_reset_protect.sv
// Operation
// - Chip reset comes from reset pin, watchdog, power-on detector or brownout.
// - Any chip reset starts the RC oscillator and initialises flash controller.
// - A low reset pin pulse of 50 ns or more is never filtered out.
// - On reset release the core fetches address 0 from the boot map.
// - Control and interrupt enable registers hold reset values before internal reset is released.
// - Brownout below one of four selected levels raises an interrupt line.
// - Brownout interrupt reaches the core only when its enable bit is set.
// - Brownout level is readable in a status register regardless of enable.
// - Four selectable brownout levels can force a full chip reset.
// - Read lock applies only when a known pattern sits in flash.
// - Firmware programming calls stay available at every lock level.
// - Level one blocks debug, limited programming, sector 0 untouched.
// - Level two blocks debug, allows only full erase then update.
// - Level three blocks debug and all ISP programming, pin entry included.
// - A separate setting disables programming entry by the entry pin.
// - Reset pin low selects boundary scan, high selects serial debug.
// - Serial debug ignores traffic while the chip is held in reset.
// - Boundary scan takes over four general pins whatever their setup.
// - The scan port gives test access only, never core debug.
// - After any chip reset the clock source is the RC oscillator.
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "rpd_defines.svh"

module rpd_reset_protect
    import rpd_pkg::*;
(
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         srst,
    // Reset sources
    input  wire logic         reset_pin_n,
    input  wire logic         wdt_reset_req,
    input  wire logic         por_detect,
    input  wire logic [3:0]   brownout_below,
    // Flash controller
    input  wire logic         flash_init_done,
    input  wire logic [31:0]  lock_word,
    input  wire logic [31:0]  pin_word,
    output logic              flash_init_req,
    // Core and clocking
    output logic              chip_reset,
    output logic              internal_rc_osc_en,
    output logic [1:0]        clk_src_sel,
    output logic              boot_map_on,
    output logic [31:0]       fetch_addr,
    output logic              brownout_irq,
    output logic              core_irq,
    // Debug and test
    input  wire logic         test_reset_n,
    input  wire logic         isp_entry_pin,
    output logic              swd_enable,
    output logic              scan_mode,
    output logic [3:0]        scan_pin_takeover,
    output logic              scan_core_debug,
    // Programming gate
    input  wire rpd_isp_cmd_t isp_cmd,
    input  wire logic         isp_cmd_valid,
    output logic              isp_cmd_ok,
    output logic              isp_pin_entry,
    output logic              iap_enable,
    output rpd_lock_t         lock_level,
    // Register port
    input  wire logic [7:0]   reg_addr,
    input  wire logic [31:0]  reg_wdata,
    input  wire logic         reg_write,
    input  wire logic         reg_read,
    output logic [31:0]       reg_rdata
);

    // Two-stage synchronisers for pin-side inputs
    logic [7:0]       sync1_reg;
    logic [7:0]       sync2_reg;
    wire logic [7:0]  sync_in;
    assign sync_in = {isp_entry_pin, test_reset_n, brownout_below, por_detect, reset_pin_n};

    always_ff @(posedge clock) begin
        if (srst) begin
            sync1_reg <= 8'h41;
            sync2_reg <= 8'h41;
        end else begin
            sync1_reg <= sync_in;
            sync2_reg <= sync1_reg;
        end
    end

    // A 50 ns low pulse spans at least one 40 ns edge, so it is always sampled
    wire logic        pin_low;
    wire logic        por_s;
    wire logic [3:0]  below_s;
    wire logic        trst_low;
    wire logic        entry_pin_s;
    assign pin_low     = ~sync2_reg[0];
    assign por_s       = sync2_reg[1];
    assign below_s     = sync2_reg[5:2];
    assign trst_low    = ~sync2_reg[6];
    assign entry_pin_s = sync2_reg[7];

    // Software registers
    logic [`RPD_CTRL_W-1:0] ctrl_reg;
    logic [`RPD_CTRL_W-1:0] ctrl_next;
    logic                   irq_en_reg;
    logic                   irq_en_next;
    logic [3:0]             cause_reg;
    logic [3:0]             cause_next;

    wire logic [1:0] irq_sel;
    wire logic [1:0] rst_sel;
    wire logic       rst_en;
    wire logic       remap_off;
    assign irq_sel   = ctrl_reg[`RPD_IRQ_SEL_LSB +: 2];
    assign rst_sel   = ctrl_reg[`RPD_RST_SEL_LSB +: 2];
    assign rst_en    = ctrl_reg[`RPD_RST_EN_BIT];
    assign remap_off = ctrl_reg[`RPD_REMAP_OFF_BIT];

    // Brownout compare against the selected levels
    wire logic brown_irq_level;
    wire logic brown_rst_level;
    assign brown_irq_level = below_s[irq_sel];
    assign brown_rst_level = rst_en & below_s[rst_sel];

    // Reset sources, packed in one assignment so the struct has a single driver
    rpd_src_t src;
    assign src = '{pin:      pin_low,
                   wdt:      wdt_reset_req,
                   por:      por_s,
                   brownout: brown_rst_level};

    wire logic reset_req;
    assign reset_req = src.pin | src.wdt | src.por | src.brownout;

    // Sequencer: hold, flash init, run
    rpd_state_t state_reg;
    rpd_state_t state_next;
    logic [3:0] hold_reg;
    logic [3:0] hold_next;

    always_comb begin
        state_next = state_reg;
        hold_next  = hold_reg;
        case (state_reg)
            RPD_HOLD: begin
                if (reset_req) begin
                    hold_next = `RPD_HOLD_CYC;
                end else if (hold_reg != 4'h0) begin
                    hold_next = hold_reg - 4'h1;
                end else begin
                    state_next = RPD_FLASH;
                end
            end
            RPD_FLASH: begin
                if (reset_req) begin
                    state_next = RPD_HOLD;
                    hold_next  = `RPD_HOLD_CYC;
                end else if (flash_init_done) begin
                    state_next = RPD_RUN;
                end
            end
            RPD_RUN: begin
                if (reset_req) begin
                    state_next = RPD_HOLD;
                    hold_next  = `RPD_HOLD_CYC;
                end
            end
            default: begin
                state_next = RPD_HOLD;
                hold_next  = `RPD_HOLD_CYC;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_reg <= RPD_HOLD;
            hold_reg  <= `RPD_HOLD_CYC;
        end else begin
            state_reg <= state_next;
            hold_reg  <= hold_next;
        end
    end

    // Reset asserts in the same cycle as the request; release waits for the run state
    assign chip_reset         = reset_req | (state_reg != RPD_RUN);
    assign internal_rc_osc_en = 1'b1;
    assign flash_init_req     = (state_reg == RPD_FLASH);

    // Lock level latched while flash init completes
    rpd_lock_t lock_reg;
    rpd_lock_t lock_next;
    logic      pin_off_reg;
    logic      pin_off_next;

    always_comb begin
        lock_next    = lock_reg;
        pin_off_next = pin_off_reg;
        if (flash_init_req && flash_init_done) begin
            if (lock_word == `RPD_LOCK1_WORD) begin
                lock_next = RPD_LVL1;
            end else if (lock_word == `RPD_LOCK2_WORD) begin
                lock_next = RPD_LVL2;
            end else if (lock_word == `RPD_LOCK3_WORD) begin
                lock_next = RPD_LVL3;
            end else begin
                lock_next = RPD_OPEN;
            end
            pin_off_next = (pin_word == `RPD_NOPIN_WORD);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            lock_reg    <= RPD_LVL3;
            pin_off_reg <= 1'b1;
        end else begin
            lock_reg    <= lock_next;
            pin_off_reg <= pin_off_next;
        end
    end

    assign lock_level = lock_reg;

    // Level two allows writes only after a full erase in this session
    logic erased_reg;
    logic erased_next;
    always_comb begin
        erased_next = erased_reg;
        if (chip_reset) begin
            erased_next = 1'b0;
        end else if (isp_cmd_valid && isp_cmd_ok && isp_cmd.op == RPD_OP_ERASE_ALL) begin
            erased_next = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            erased_reg <= 1'b0;
        end else begin
            erased_reg <= erased_next;
        end
    end

    // Programming command filter per lock level
    wire logic sec_nonzero;
    wire logic lvl1_ok;
    wire logic lvl2_ok;
    assign sec_nonzero = (isp_cmd.sector != 4'h0);
    assign lvl1_ok = ((isp_cmd.op == RPD_OP_WRITE) | (isp_cmd.op == RPD_OP_ERASE_SEC)) & sec_nonzero;
    assign lvl2_ok = (isp_cmd.op == RPD_OP_ERASE_ALL) | ((isp_cmd.op == RPD_OP_WRITE) & erased_reg);

    always_comb begin
        case (lock_reg)
            RPD_OPEN: isp_cmd_ok = 1'b1;
            RPD_LVL1: isp_cmd_ok = lvl1_ok;
            RPD_LVL2: isp_cmd_ok = lvl2_ok;
            RPD_LVL3: isp_cmd_ok = 1'b0;
            default:  isp_cmd_ok = 1'b0;
        endcase
    end

    assign isp_pin_entry = entry_pin_s & ~pin_off_reg & (lock_reg != RPD_LVL3);
    assign iap_enable    = 1'b1;

    // Debug and boundary scan selection
    logic scan_reg;
    logic scan_next;
    always_comb begin
        scan_next = scan_reg;
        if (trst_low) begin
            scan_next = 1'b0;
        end else if (pin_low) begin
            scan_next = 1'b1;
        end else begin
            scan_next = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            scan_reg <= 1'b0;
        end else begin
            scan_reg <= scan_next;
        end
    end

    assign scan_mode         = scan_reg;
    assign scan_pin_takeover = {4{scan_reg}};
    assign scan_core_debug   = 1'b0;
    // Debug port stays dead during reset, in scan mode and under any lock
    assign swd_enable = ~chip_reset & ~scan_reg & (lock_reg == RPD_OPEN);

    // Brownout interrupt and boot map
    assign brownout_irq = brown_irq_level;
    assign core_irq     = brown_irq_level & irq_en_reg;
    assign boot_map_on  = ~remap_off;
    assign fetch_addr   = `RPD_BOOT_VECTOR;
    assign clk_src_sel  = ctrl_reg[`RPD_CLK_SRC_LSB +: 2];

    // Register decode
    wire logic wr_ctrl;
    wire logic wr_cause;
    wire logic wr_irq_en;
    assign wr_ctrl   = reg_write & (reg_addr == `RPD_CTRL_OFS);
    assign wr_cause  = reg_write & (reg_addr == `RPD_CAUSE_OFS);
    assign wr_irq_en = reg_write & (reg_addr == `RPD_IRQEN_OFS);

    wire logic [3:0] cause_set;
    assign cause_set = {src.brownout, src.por, src.wdt, src.pin};

    always_comb begin
        ctrl_next   = ctrl_reg;
        irq_en_next = irq_en_reg;
        if (chip_reset) begin
            ctrl_next   = `RPD_CTRL_RST;
            irq_en_next = 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_next = reg_wdata[`RPD_CTRL_W-1:0];
            end
            if (wr_irq_en) begin
                irq_en_next = reg_wdata[0];
            end
        end
        // Write one to clear; a new cause in the same cycle wins
        cause_next = (cause_reg & ~(wr_cause ? reg_wdata[3:0] : 4'h0)) | cause_set;
    end

    // Cause bits survive chip reset so software can see why it restarted
    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl_reg   <= `RPD_CTRL_RST;
            irq_en_reg <= 1'b0;
            cause_reg  <= 4'h0;
        end else begin
            ctrl_reg   <= ctrl_next;
            irq_en_reg <= irq_en_next;
            cause_reg  <= cause_next;
        end
    end

    // Read data, one cycle after the strobe
    logic [31:0] status_word;
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`RPD_ST_IRQ_BIT]       = brown_irq_level;
        status_word[`RPD_ST_LEVEL_BIT]     = below_s[irq_sel];
        status_word[`RPD_ST_LOCK_LSB +: 2] = lock_reg;
        status_word[`RPD_ST_SCAN_BIT]      = scan_reg;
        status_word[`RPD_ST_PINOFF_BIT]    = pin_off_reg;
    end

    logic [31:0] rd_mux;
    always_comb begin
        case (reg_addr)
            `RPD_CTRL_OFS:   rd_mux = {24'h000000, ctrl_reg};
            `RPD_STATUS_OFS: rd_mux = status_word;
            `RPD_CAUSE_OFS:  rd_mux = {28'h0000000, cause_reg};
            `RPD_IRQEN_OFS:  rd_mux = {31'h0, irq_en_reg};
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    logic [31:0] rdata_reg;
    always_ff @(posedge clock) begin
        if (srst) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= reg_read ? rd_mux : 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_reg;

endmodule

// file: rpd_reset_protect_checker.sv
`timescale 1ns/1ps

module rpd_reset_protect_checker
    import rpd_pkg::*;
(
    // Clock and reset
    input wire logic         clock,
    input wire logic         srst,
    // Sources and flash
    input wire logic         reset_pin_n,
    input wire logic         flash_init_req,
    input wire logic         flash_init_done,
    // Core side
    input wire logic         chip_reset,
    input wire logic [1:0]   clk_src_sel,
    input wire logic [31:0]  fetch_addr,
    input wire logic         brownout_irq,
    input wire logic         core_irq,
    // Debug and programming
    input wire logic         swd_enable,
    input wire logic         scan_mode,
    input wire logic [3:0]   scan_pin_takeover,
    input wire logic         scan_core_debug,
    input wire rpd_isp_cmd_t isp_cmd,
    input wire logic         isp_cmd_ok,
    input wire logic         isp_pin_entry,
    input wire logic         iap_enable,
    input wire rpd_lock_t    lock_level
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    // Two synchroniser stages; chip_reset follows the synchronised pin combinationally
    AST_PIN_RESET: assert property (!reset_pin_n [*2] |-> ##[0:3] chip_reset)
        else $error("pin pulse did not reset the chip");
    AST_FLASH_FIRST: assert property ($fell(chip_reset) |-> $past(flash_init_req && flash_init_done))
        else $error("reset released before flash init");
    AST_FETCH_ZERO: assert property ($fell(chip_reset) |-> fetch_addr == 32'h0000_0000)
        else $error("fetch address not zero at release");
    AST_CLK_RC: assert property (chip_reset [*2] |-> clk_src_sel == 2'h0)
        else $error("clock source not RC during reset");
    AST_IRQ_GATE: assert property (core_irq |-> brownout_irq)
        else $error("core irq without brownout");
    AST_SWD_RESET: assert property (chip_reset |-> !swd_enable)
        else $error("debug port live in reset");
    AST_SWD_LOCK: assert property (lock_level != RPD_OPEN |-> !swd_enable)
        else $error("debug port live under lock");
    AST_SCAN_PINS: assert property (scan_pin_takeover == {4{scan_mode}})
        else $error("scan pins not taken over");
    AST_SCAN_NODBG: assert property (scan_mode |-> !scan_core_debug && !swd_enable)
        else $error("scan port offers core debug");
    AST_LVL3_SHUT: assert property (lock_level == RPD_LVL3 |-> !isp_pin_entry && !isp_cmd_ok)
        else $error("programming open at level three");
    AST_LVL1_SEC0: assert property (lock_level == RPD_LVL1 && isp_cmd.sector == 4'h0
        && isp_cmd.op inside {RPD_OP_WRITE, RPD_OP_ERASE_SEC} |-> !isp_cmd_ok)
        else $error("sector zero touched at level one");
    AST_IAP_ON: assert property (lock_level != RPD_OPEN |-> iap_enable)
        else $error("firmware programming blocked");

    COV_SCAN: cover property (scan_mode && chip_reset);
    COV_IRQ: cover property (core_irq);
    COV_LVL2: cover property (lock_level == RPD_LVL2 && isp_cmd_ok);
endmodule

bind rpd_reset_protect rpd_reset_protect_checker u_chk (
    .clock, .srst, .reset_pin_n, .flash_init_req, .flash_init_done, .chip_reset,
    .clk_src_sel, .fetch_addr, .brownout_irq, .core_irq, .swd_enable, .scan_mode,
    .scan_pin_takeover, .scan_core_debug, .isp_cmd, .isp_cmd_ok, .isp_pin_entry,
    .iap_enable, .lock_level
);

// file: rpd_probe_model.sv
`timescale 1ns/1ps

module rpd_probe_model #(
    parameter int SETTLE_CYC = 6250
) (
    // Clock
    input wire logic clock,
    // Pins driven by the tester
    output logic     reset_pin_n,
    output logic     test_reset_n
);
    // Board pull-up keeps both lines high when idle
    initial begin
        reset_pin_n = 1'b1;
        test_reset_n = 1'b1;
    end

    task automatic pulse_reset(input int cyc);
        @(posedge clock);
        reset_pin_n <= 1'b0;
        repeat (cyc) @(posedge clock);
        reset_pin_n <= 1'b1;
    endtask

    // Flash is assumed erased by the bench before entry
    task automatic scan_enter;
        @(posedge clock);
        reset_pin_n <= 1'b1;
        test_reset_n <= 1'b1;
        repeat (SETTLE_CYC) @(posedge clock);
        reset_pin_n <= 1'b0;
        repeat (4) @(posedge clock);
    endtask

    task automatic scan_exit;
        @(posedge clock);
        test_reset_n <= 1'b0;
        repeat (4) @(posedge clock);
        reset_pin_n <= 1'b1;
        @(posedge clock);
        test_reset_n <= 1'b1;
    endtask
endmodule

// file: tb_rpd_reset_protect.sv
`timescale 1ns/1ps
`include "rpd_defines.svh"

module tb_rpd_reset_protect;
    import rpd_pkg::*;
    logic clock = 1'b0, srst = 1'b1, wdt_reset_req = 1'b0, por_detect = 1'b0;
    logic [3:0] brownout_below = 4'h0;
    logic flash_init_done = 1'b0, flash_init_req, chip_reset, reset_pin_n, test_reset_n;
    logic [31:0] lock_word = 32'h0, pin_word = 32'h0, reg_wdata = 32'h0, reg_rdata, fetch_addr;
    logic [7:0] reg_addr = 8'h00;
    logic reg_write = 1'b0, reg_read = 1'b0, isp_entry_pin = 1'b0, isp_cmd_valid = 1'b0;
    logic [1:0] clk_src_sel;
    logic boot_map_on, brownout_irq, core_irq, swd_enable, scan_mode, scan_core_debug, internal_rc_osc_en;
    logic isp_cmd_ok, isp_pin_entry, iap_enable;
    logic [3:0] scan_pin_takeover;
    rpd_isp_cmd_t isp_cmd = '{op: RPD_OP_READ, sector: 4'h0};
    rpd_lock_t lock_level;
    int mismatches = 0, samples_checked = 0;

    always #20 clock = ~clock;
    // Prompt flash controller
    always @(posedge clock) flash_init_done <= flash_init_req;

    rpd_probe_model probe (.clock(clock), .reset_pin_n(reset_pin_n), .test_reset_n(test_reset_n));

    rpd_reset_protect dut (
        .clock(clock), .srst(srst), .reset_pin_n(reset_pin_n), .wdt_reset_req(wdt_reset_req),
        .por_detect(por_detect), .brownout_below(brownout_below), .flash_init_done(flash_init_done),
        .lock_word(lock_word), .pin_word(pin_word), .flash_init_req(flash_init_req),
        .chip_reset(chip_reset), .internal_rc_osc_en(internal_rc_osc_en), .clk_src_sel(clk_src_sel),
        .boot_map_on(boot_map_on), .fetch_addr(fetch_addr), .brownout_irq(brownout_irq),
        .core_irq(core_irq), .test_reset_n(test_reset_n), .isp_entry_pin(isp_entry_pin),
        .swd_enable(swd_enable), .scan_mode(scan_mode), .scan_pin_takeover(scan_pin_takeover),
        .scan_core_debug(scan_core_debug), .isp_cmd(isp_cmd), .isp_cmd_valid(isp_cmd_valid),
        .isp_cmd_ok(isp_cmd_ok), .isp_pin_entry(isp_pin_entry), .iap_enable(iap_enable),
        .lock_level(lock_level), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Waits for the reset to be seen, then for its release
    task automatic wait_run;
        int n;
        n = 0;
        while (chip_reset !== 1'b1 && n < 8) begin
            @(posedge clock);
            #1 n++;
        end
        chk(chip_reset, 1'b1);
        n = 0;
        while (chip_reset !== 1'b0 && n < 200) begin
            @(posedge clock);
            #1 n++;
        end
        chk(chip_reset, 1'b0);
        chk(fetch_addr, 32'h0);
        chk(boot_map_on, 1'b1);
        chk(clk_src_sel, `RPD_CLK_RC);
        chk(internal_rc_osc_en, 1'b1);
    endtask

    task automatic reboot;
        @(posedge clock);
        wdt_reset_req <= 1'b1;
        @(posedge clock);
        wdt_reset_req <= 1'b0;
        wait_run();
    endtask

    task automatic isp_try(input rpd_op_t op, input logic [3:0] sec, input logic exp);
        @(posedge clock);
        isp_cmd <= '{op: op, sector: sec};
        isp_cmd_valid <= 1'b1;
        #1 chk(isp_cmd_ok, exp);
        @(posedge clock);
        isp_cmd_valid <= 1'b0;
    endtask

    task automatic t_sources;
        logic [31:0] d;
        reg_rd(8'h40, d);
        chk(d, 32'h0);
        for (int i = 0; i < 3; i++) begin
            reg_wr(`RPD_CTRL_OFS, 32'hE0);
            #1 chk(clk_src_sel, 2'h3);
            if (i == 0) probe.pulse_reset(2); // 80 ns pulse
            else begin
                @(posedge clock);
                wdt_reset_req <= (i == 1);
                por_detect <= (i == 2);
                repeat (3) @(posedge clock);
                wdt_reset_req <= 1'b0;
                por_detect <= 1'b0;
            end
            wait_run();
            reg_rd(`RPD_CAUSE_OFS, d);
            chk(d, 32'h1 << i);
            reg_wr(`RPD_CAUSE_OFS, 32'hF);
            reg_rd(`RPD_CTRL_OFS, d);
            chk(d, {24'h0, `RPD_CTRL_RST});
        end
    endtask

    task automatic t_brownout;
        logic [31:0] d;
        for (int k = 0; k < 4; k++) begin
            reg_wr(`RPD_CTRL_OFS, k);
            brownout_below <= 4'hF ^ (4'h1 << k);
            repeat (4) @(posedge clock);
            #1 chk(brownout_irq, 1'b0);
            brownout_below <= 4'h1 << k;
            repeat (4) @(posedge clock);
            #1 chk(brownout_irq, 1'b1);
            chk(core_irq, 1'b0);
            reg_rd(`RPD_STATUS_OFS, d);
            chk(d[0], 1'b1);
            reg_wr(`RPD_IRQEN_OFS, 32'h1);
            #1 chk(core_irq, 1'b1);
            reg_wr(`RPD_CTRL_OFS, 32'h10 | (k << 2));
            repeat (4) @(posedge clock);
            brownout_below <= 4'h0;
            wait_run();
            reg_rd(`RPD_CAUSE_OFS, d);
            chk(d, 32'h8);
            reg_wr(`RPD_CAUSE_OFS, 32'hF);
        end
    endtask

    task automatic t_locks;
        logic [31:0] w [4];
        logic [31:0] d;
        w = '{32'h0, `RPD_LOCK1_WORD, `RPD_LOCK2_WORD, `RPD_LOCK3_WORD};
        isp_entry_pin <= 1'b1;
        for (int l = 0; l < 5; l++) begin
            lock_word <= (l < 4) ? w[l] : 32'h0;
            pin_word <= (l == 4) ? `RPD_NOPIN_WORD : 32'h0;
            reboot();
            chk(isp_pin_entry, l < 3);
            if (l < 4) begin
                chk(lock_level, l);
                chk(swd_enable, l == 0);
                chk(iap_enable, 1'b1);
                reg_rd(`RPD_STATUS_OFS, d);
                chk(d[3:2], l);
                isp_try(RPD_OP_WRITE, 4'h0, l == 0);
                isp_try(RPD_OP_ERASE_SEC, 4'h1, l < 2);
                isp_try(RPD_OP_WRITE, 4'h1, l < 2);
                isp_try(RPD_OP_ERASE_ALL, 4'h0, l == 0 || l == 2);
                isp_try(RPD_OP_WRITE, 4'h1, l < 3);
            end
        end
        pin_word <= 32'h0;
    endtask

    task automatic t_scan;
        probe.scan_enter();
        #1 chk(scan_mode, 1'b1);
        chk(scan_pin_takeover, 4'hF);
        chk(scan_core_debug, 1'b0);
        chk(swd_enable, 1'b0);
        probe.scan_exit();
        wait_run();
        chk(scan_mode, 1'b0);
        chk(swd_enable, 1'b1);
    endtask

    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        wait_run();
        t_sources();
        t_brownout();
        t_locks();
        t_scan();
        finish_test();
    end

    // Scan entry alone needs 6250 cycles; the rest is a few hundred
    initial begin
        #(40 * 30000);
        mismatches++;
        finish_test();
    end
endmodule
